// ---- rtl/vlh_host_ctrl.sv ----
`timescale 1ns/100ps
module vlh_host_ctrl #(
	parameter int unsigned PORT_SWITCH_CYCLES = vlh_pkg::PORT_SWITCH_CYC,
	parameter int unsigned RESET_CYCLES       = vlh_pkg::RESET_PULSE_CYC,
	parameter int unsigned QUARTER_CYCLES     = vlh_pkg::I2C_QUARTER_CYC
) (
	input  wire logic                     clk_i,              // 200 MHz clock
	input  wire logic                     rst_i,              // Synchronous reset, active high
	input  wire logic                     ce_i,               // Clock enable
	input  wire logic [vlh_pkg::AW-1:0]   s_awaddr_i,         // AXI write address
	input  wire logic                     s_awvalid_i,        // AXI write address valid
	output logic                          s_awready_o,        // AXI write address ready
	input  wire logic [31:0]              s_wdata_i,          // AXI write data
	input  wire logic [3:0]               s_wstrb_i,          // AXI write strobes
	input  wire logic                     s_wvalid_i,         // AXI write data valid
	output logic                          s_wready_o,         // AXI write data ready
	output logic [1:0]                    s_bresp_o,          // AXI write response
	output logic                          s_bvalid_o,         // AXI write response valid
	input  wire logic                     s_bready_i,         // AXI write response ready
	input  wire logic [vlh_pkg::AW-1:0]   s_araddr_i,         // AXI read address
	input  wire logic                     s_arvalid_i,        // AXI read address valid
	output logic                          s_arready_o,        // AXI read address ready
	output logic [31:0]                   s_rdata_o,          // AXI read data
	output logic [1:0]                    s_rresp_o,          // AXI read response
	output logic                          s_rvalid_o,         // AXI read valid
	input  wire logic                     s_rready_i,         // AXI read ready
	output logic                          irq_o,              // Level interrupt, active high
	output logic                          tx_rst_n_o,         // Transmitter reset, active low
	output logic                          rx_rst_n_o,         // Receiver reset, active low
	input  wire logic                     tx_int_n_i,         // Transmitter interrupt, active low
	input  wire logic                     rx_int_n_i,         // Receiver interrupt, active low
	output logic [vlh_pkg::NBUS-1:0]      mgmt_scl_o,         // Clock line value, always 0
	output logic [vlh_pkg::NBUS-1:0]      mgmt_scl_oe_o,      // Clock line driven low
	input  wire logic [vlh_pkg::NBUS-1:0] mgmt_sda_i,         // Data line level
	output logic [vlh_pkg::NBUS-1:0]      mgmt_sda_o,         // Data line value, always 0
	output logic [vlh_pkg::NBUS-1:0]      mgmt_sda_oe_o,      // Data line driven low
	output logic                          display_id_eeprom_write_guard_o, // EEPROM write guard
	output logic                          port_one_hotplug_enable_low_o,   // Port 1 hot-plug enable, low
	output logic                          port_two_hotplug_enable_low_o,   // Port 2 hot-plug enable, low
	output logic                          active_port_o,      // 0 = port 1, 1 = port 2
	output logic                          video_out_en_o      // Video and audio drive allowed
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] vlh_merge(input logic [31:0] old_v, input logic [31:0] new_v,
	                                           input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : vlh_merge

	function automatic logic vlh_mapped(input logic [vlh_pkg::AW-1:0] a);
		return (a == vlh_pkg::REG_CTRL) || (a == vlh_pkg::REG_STATUS) || (a == vlh_pkg::REG_CMD) ||
		       (a == vlh_pkg::REG_RDATA) || (a == vlh_pkg::REG_IRQ_STAT) || (a == vlh_pkg::REG_IRQ_MASK);
	endfunction : vlh_mapped

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	vlh_pkg::vlh_ctrl_t          ctrl_q;
	vlh_pkg::vlh_ctrl_t          ctrl_wr;
	logic [vlh_pkg::IRQ_W-1:0]   irq_stat_q;
	logic [vlh_pkg::IRQ_W-1:0]   irq_mask_q;
	logic [vlh_pkg::IRQ_W-1:0]   irq_set;
	logic [vlh_pkg::IRQ_W-1:0]   irq_clr;
	logic                        wr_go;
	logic                        rd_go;
	logic                        wr_ctrl;
	logic [31:0]                 rd_val;
	logic [1:0]                  int_s1_q;
	logic [1:0]                  int_s2_q;
	logic [1:0]                  int_prev_q;
	logic [vlh_pkg::NBUS-1:0]    sda_s1_q;
	logic [vlh_pkg::NBUS-1:0]    sda_s2_q;
	logic [1:0]                  rst_n_q;
	logic [1:0]                  rst_go;
	logic [1:0]                  bus_q;
	logic                        cmd_go;
	logic [1:0]                  cmd_bus;
	vlh_pkg::vlh_op_t            cmd_op;
	logic [7:0]                  cmd_byte;
	logic [7:0]                  dev_addr;
	logic                        eng_busy;
	logic                        eng_done;
	logic [7:0]                  eng_rdata;
	logic                        eng_ack;
	logic                        scl_low;
	logic                        sda_low;
	logic [31:0]                 sw_cnt_q;
	logic                        auto_run;
	logic                        sw_due;

	assign wr_go   = s_awvalid_i & s_wvalid_i & ~s_awready_o & ~s_bvalid_o;
	assign rd_go   = s_arvalid_i & ~s_arready_o & ~s_rvalid_o;
	assign wr_ctrl = wr_go & (s_awaddr_i == vlh_pkg::REG_CTRL);
	assign ctrl_wr = vlh_pkg::vlh_ctrl_t'(9'(vlh_merge({23'h0, ctrl_q}, s_wdata_i, s_wstrb_i)));

	// ------------------------------------------------------------
	// AXI4-Lite slave handshakes
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_awready_o <= 1'b0;
			s_wready_o  <= 1'b0;
			s_bvalid_o  <= 1'b0;
			s_bresp_o   <= vlh_pkg::RESP_OKAY;
		end else if (ce_i) begin
			s_awready_o <= wr_go;
			s_wready_o  <= wr_go;
			if (wr_go) begin
				s_bvalid_o <= 1'b1;
				s_bresp_o  <= vlh_mapped(s_awaddr_i) ? vlh_pkg::RESP_OKAY : vlh_pkg::RESP_SLVERR;
			end else if (s_bready_i) begin
				s_bvalid_o <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_val = 32'h0;
		unique case (s_araddr_i)
			vlh_pkg::REG_CTRL:     rd_val = {23'h0, ctrl_q};
			vlh_pkg::REG_STATUS: begin
				rd_val[vlh_pkg::ST_TX_RST] = ~rst_n_q[0];
				rd_val[vlh_pkg::ST_RX_RST] = ~rst_n_q[1];
				rd_val[vlh_pkg::ST_PORT]   = active_port_o;
				rd_val[vlh_pkg::ST_BUSY]   = eng_busy;
				rd_val[vlh_pkg::ST_ACK]    = eng_ack;
				rd_val[vlh_pkg::ST_TX_INT] = ~int_s2_q[0];
				rd_val[vlh_pkg::ST_RX_INT] = ~int_s2_q[1];
				rd_val[vlh_pkg::ST_VIDEO]  = video_out_en_o;
			end
			vlh_pkg::REG_RDATA:    rd_val = {24'h0, eng_rdata};
			vlh_pkg::REG_IRQ_STAT: rd_val = {28'h0, irq_stat_q};
			vlh_pkg::REG_IRQ_MASK: rd_val = {28'h0, irq_mask_q};
			default:               rd_val = 32'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_arready_o <= 1'b0;
			s_rvalid_o  <= 1'b0;
			s_rdata_o   <= 32'h0;
			s_rresp_o   <= vlh_pkg::RESP_OKAY;
		end else if (ce_i) begin
			s_arready_o <= rd_go;
			if (rd_go) begin
				s_rvalid_o <= 1'b1;
				s_rdata_o  <= rd_val;
				s_rresp_o  <= vlh_mapped(s_araddr_i) ? vlh_pkg::RESP_OKAY : vlh_pkg::RESP_SLVERR;
			end else if (s_rready_i) begin
				s_rvalid_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Control, write guard, hot-plug and video gate
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= vlh_pkg::CTRL_RESET;
		end else if (ce_i && wr_ctrl) begin
			ctrl_q             <= ctrl_wr;
			ctrl_q.tx_reset_go <= 1'b0;
			ctrl_q.rx_reset_go <= 1'b0;
			if (!ctrl_wr.sink_attached) begin
				ctrl_q.video_en <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			display_id_eeprom_write_guard_o <= 1'b1;
			port_one_hotplug_enable_low_o   <= 1'b1;
			port_two_hotplug_enable_low_o   <= 1'b1;
			video_out_en_o                  <= 1'b0;
		end else if (ce_i) begin
			display_id_eeprom_write_guard_o <= ~ctrl_q.ee_write_en;
			port_one_hotplug_enable_low_o   <= ~ctrl_q.hotplug_en;
			port_two_hotplug_enable_low_o   <= ~ctrl_q.hotplug_en;
			// Video only after a sink is attached and the transmitter is out of reset;
			// a software reset pulse drops it at once so video never overlaps the reset
			video_out_en_o <= ctrl_q.video_en & ctrl_q.sink_attached & rst_n_q[0] & ~rst_go[0];
		end
	end

	// ------------------------------------------------------------
	// Chip reset pulses, started by reset and by software
	// ------------------------------------------------------------
	assign rst_go = {wr_ctrl & ctrl_wr.rx_reset_go, wr_ctrl & ctrl_wr.tx_reset_go};

	for (genvar c = 0; c < 2; c++) begin : g_chip_rst
		logic [31:0] cnt_q;
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				cnt_q      <= RESET_CYCLES;
				rst_n_q[c] <= 1'b0;
			end else if (ce_i) begin
				if (rst_go[c]) begin
					cnt_q      <= RESET_CYCLES;
					rst_n_q[c] <= 1'b0;
				end else if (cnt_q != 32'h0) begin
					cnt_q <= cnt_q - 32'h1;
				end else begin
					rst_n_q[c] <= 1'b1;
				end
			end
		end
	end

	assign tx_rst_n_o = rst_n_q[0];
	assign rx_rst_n_o = rst_n_q[1];

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_s1_q   <= 2'h3;
			int_s2_q   <= 2'h3;
			int_prev_q <= 2'h3;
			sda_s1_q   <= '1;
			sda_s2_q   <= '1;
		end else if (ce_i) begin
			int_s1_q   <= {rx_int_n_i, tx_int_n_i};
			int_s2_q   <= int_s1_q;
			int_prev_q <= int_s2_q;
			sda_s1_q   <= mgmt_sda_i;
			sda_s2_q   <= sda_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Management bus commands
	// ------------------------------------------------------------
	assign cmd_bus = s_wdata_i[vlh_pkg::CMD_BUS_LSB +: 2];
	assign cmd_op  = vlh_pkg::vlh_op_t'(s_wdata_i[vlh_pkg::CMD_OP_LSB +: 3]);

	always_comb begin
		unique case (cmd_bus)
			vlh_pkg::BUS_TX: dev_addr = vlh_pkg::TX_DEV_ADDR;
			vlh_pkg::BUS_RX: dev_addr = vlh_pkg::RX_DEV_ADDR;
			default:         dev_addr = vlh_pkg::EE_DEV_ADDR;
		endcase
	end

	// Address primitive puts the chip address in front of the read/write bit
	assign cmd_byte = (cmd_op == vlh_pkg::OP_ADDR) ?
	                  {dev_addr[7:1], s_wdata_i[vlh_pkg::CMD_DATA_LSB]} :
	                  s_wdata_i[vlh_pkg::CMD_DATA_LSB +: 8];

	// A chip held in reset cannot be initialised, so its commands are dropped
	assign cmd_go = wr_go && (s_awaddr_i == vlh_pkg::REG_CMD) && !eng_busy && (cmd_bus != 2'h3) &&
	                (cmd_op <= vlh_pkg::OP_ADDR) &&
	                !((cmd_bus == vlh_pkg::BUS_TX) && !rst_n_q[0]) &&
	                !((cmd_bus == vlh_pkg::BUS_RX) && !rst_n_q[1]);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_q <= vlh_pkg::BUS_TX;
		end else if (ce_i && cmd_go) begin
			bus_q <= cmd_bus;
		end
	end

	vlh_i2c_engine #(
		.QUARTER_CYC (QUARTER_CYCLES)
	) u_engine (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.ce_i      (ce_i),
		.start_i   (cmd_go),
		.op_i      (cmd_op),
		.byte_i    (cmd_byte),
		.ack_i     (s_wdata_i[vlh_pkg::CMD_ACK_BIT]),
		.sda_i     (sda_s2_q[bus_q]),
		.busy_o    (eng_busy),
		.done_o    (eng_done),
		.rdata_o   (eng_rdata),
		.ack_o     (eng_ack),
		.scl_low_o (scl_low),
		.sda_low_o (sda_low)
	);

	// Idle buses are released, which leaves the EEPROM lines to the source
	for (genvar b = 0; b < vlh_pkg::NBUS; b++) begin : g_bus_pins
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				mgmt_scl_o[b]    <= 1'b0;
				mgmt_sda_o[b]    <= 1'b0;
				mgmt_scl_oe_o[b] <= 1'b0;
				mgmt_sda_oe_o[b] <= 1'b0;
			end else if (ce_i) begin
				mgmt_scl_oe_o[b] <= (bus_q == 2'(b)) & scl_low;
				mgmt_sda_oe_o[b] <= (bus_q == 2'(b)) & sda_low;
			end
		end
	end

	// ------------------------------------------------------------
	// Active port and switch timer
	// ------------------------------------------------------------
	assign auto_run = ctrl_q.auto_switch & ~ctrl_q.source_found & rst_n_q[1];
	assign sw_due   = auto_run && (sw_cnt_q == PORT_SWITCH_CYCLES - 1) && !wr_ctrl;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_port_o <= 1'b0;
			sw_cnt_q      <= 32'h0;
		end else if (ce_i) begin
			// One bit of state names the single active port
			if (wr_ctrl) begin
				active_port_o <= ctrl_wr.port_sel;
			end else if (sw_due) begin
				active_port_o <= ~active_port_o;
			end
			if (!auto_run || sw_due || (wr_ctrl && ctrl_wr.port_sel != active_port_o)) begin
				sw_cnt_q <= 32'h0;
			end else begin
				sw_cnt_q <= sw_cnt_q + 32'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, cleared by read, set wins
	// ------------------------------------------------------------
	always_comb begin
		irq_set                      = '0;
		irq_set[vlh_pkg::IRQ_TX_INT] = int_prev_q[0] & ~int_s2_q[0];
		irq_set[vlh_pkg::IRQ_RX_INT] = int_prev_q[1] & ~int_s2_q[1];
		irq_set[vlh_pkg::IRQ_DONE]   = eng_done;
		irq_set[vlh_pkg::IRQ_SWITCH] = sw_due;
		irq_clr = (rd_go && s_araddr_i == vlh_pkg::REG_IRQ_STAT) ? irq_stat_q : '0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= '0;
			irq_mask_q <= vlh_pkg::MASK_RESET;
			irq_o      <= 1'b0;
		end else if (ce_i) begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			if (wr_go && s_awaddr_i == vlh_pkg::REG_IRQ_MASK) begin
				irq_mask_q <= 4'(vlh_merge({28'h0, irq_mask_q}, s_wdata_i, s_wstrb_i));
			end
			irq_o <= |(irq_stat_q & irq_mask_q);
		end
	end

endmodule : vlh_host_ctrl

// ---- inc/vlh_pkg.sv ----
package vlh_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 200_000_000;
	localparam int unsigned CLK_MHZ         = 200;
	localparam int unsigned RESET_PULSE_NS  = 10_000;
	localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned I2C_QUARTER_NS  = 2_500;
	localparam int unsigned I2C_QUARTER_CYC = (I2C_QUARTER_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned PORT_SWITCH_S   = 3;
	localparam int unsigned PORT_SWITCH_CYC = PORT_SWITCH_S * CLK_HZ;

	// ------------------------------------------------------------
	// Management buses and chip addresses
	// ------------------------------------------------------------
	localparam int unsigned NBUS        = 3;
	localparam logic [1:0]  BUS_TX      = 2'h0;
	localparam logic [1:0]  BUS_RX      = 2'h1;
	localparam logic [1:0]  BUS_EE      = 2'h2;
	localparam logic [7:0]  TX_DEV_ADDR = 8'h98;
	localparam logic [7:0]  RX_DEV_ADDR = 8'h90;
	localparam logic [7:0]  EE_DEV_ADDR = 8'hA0;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int unsigned AW           = 8;
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_STATUS   = 8'h04;
	localparam logic [7:0]  REG_CMD      = 8'h08;
	localparam logic [7:0]  REG_RDATA    = 8'h0C;
	localparam logic [7:0]  REG_IRQ_STAT = 8'h10;
	localparam logic [7:0]  REG_IRQ_MASK = 8'h14;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// Command register fields
	localparam int unsigned CMD_OP_LSB   = 0;
	localparam int unsigned CMD_BUS_LSB  = 4;
	localparam int unsigned CMD_ACK_BIT  = 6;
	localparam int unsigned CMD_DATA_LSB = 8;

	// Status register fields
	localparam int unsigned ST_TX_RST    = 0;
	localparam int unsigned ST_RX_RST    = 1;
	localparam int unsigned ST_PORT      = 2;
	localparam int unsigned ST_BUSY      = 3;
	localparam int unsigned ST_ACK       = 4;
	localparam int unsigned ST_TX_INT    = 5;
	localparam int unsigned ST_RX_INT    = 6;
	localparam int unsigned ST_VIDEO     = 7;

	// Interrupt status and mask fields
	localparam int unsigned IRQ_W        = 4;
	localparam int unsigned IRQ_TX_INT   = 0;
	localparam int unsigned IRQ_RX_INT   = 1;
	localparam int unsigned IRQ_DONE     = 2;
	localparam int unsigned IRQ_SWITCH   = 3;
	localparam logic [3:0]  MASK_RESET   = 4'h0;

	// Control register, bit 0 is tx_reset_go
	typedef struct packed {
		logic port_sel;
		logic video_en;
		logic sink_attached;
		logic source_found;
		logic auto_switch;
		logic hotplug_en;
		logic ee_write_en;
		logic rx_reset_go;
		logic tx_reset_go;
	} vlh_ctrl_t;
	localparam vlh_ctrl_t CTRL_RESET = 9'h000;

	typedef enum logic [2:0] {
		OP_START,
		OP_STOP,
		OP_WRITE,
		OP_READ,
		OP_ADDR
	} vlh_op_t;

endpackage : vlh_pkg

// ---- rtl/vlh_i2c_engine.sv ----
`timescale 1ns/100ps
module vlh_i2c_engine #(
	parameter int unsigned QUARTER_CYC = vlh_pkg::I2C_QUARTER_CYC
) (
	input  wire logic            clk_i,     // System clock
	input  wire logic            rst_i,     // Synchronous reset
	input  wire logic            ce_i,      // Clock enable
	input  wire logic            start_i,   // Start one primitive
	input  wire vlh_pkg::vlh_op_t op_i,     // Primitive to run
	input  wire logic [7:0]      byte_i,    // Byte to send
	input  wire logic            ack_i,     // Ack bit sent after a read
	input  wire logic            sda_i,     // Synchronised data line
	output logic                 busy_o,    // Primitive in progress
	output logic                 done_o,    // Primitive finished
	output logic [7:0]           rdata_o,   // Byte received
	output logic                 ack_o,     // Ack bit seen, 0 = acked
	output logic                 scl_low_o, // Pull clock low
	output logic                 sda_low_o  // Pull data low
);

	localparam int QW = $clog2(QUARTER_CYC + 1);

	typedef enum logic [1:0] {ENG_IDLE, ENG_START, ENG_STOP, ENG_BITS} vlh_eng_t;

	vlh_eng_t       state_q;
	logic [QW-1:0]  qcnt_q;
	logic [1:0]     phase_q;
	logic [3:0]     bit_q;
	logic [8:0]     shift_q;
	logic [8:0]     rxsh_q;
	logic           tick;

	assign tick   = (qcnt_q == QW'(QUARTER_CYC - 1));
	assign busy_o = (state_q != ENG_IDLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q   <= ENG_IDLE;
			qcnt_q    <= '0;
			phase_q   <= 2'h0;
			bit_q     <= 4'h0;
			shift_q   <= 9'h1FF;
			rxsh_q    <= 9'h000;
			done_o    <= 1'b0;
			rdata_o   <= 8'h00;
			ack_o     <= 1'b1;
			scl_low_o <= 1'b0;
			sda_low_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (state_q == ENG_IDLE) begin
				qcnt_q  <= '0;
				phase_q <= 2'h0;
				bit_q   <= 4'h0;
				if (start_i) begin
					unique case (op_i)
						vlh_pkg::OP_START: state_q <= ENG_START;
						vlh_pkg::OP_STOP:  state_q <= ENG_STOP;
						default:           state_q <= ENG_BITS;
					endcase
					// A read releases data for eight bits and then sends our ack
					shift_q <= (op_i == vlh_pkg::OP_READ) ? {8'hFF, ack_i} : {byte_i, 1'b1};
				end
			end else begin
				qcnt_q <= tick ? '0 : qcnt_q + QW'(1);
				if (tick) begin
					phase_q <= phase_q + 2'h1;
					unique case (state_q)
						ENG_START: begin
							unique case (phase_q)
								2'h0: sda_low_o <= 1'b0;
								2'h1: scl_low_o <= 1'b0;
								2'h2: sda_low_o <= 1'b1;
								2'h3: begin
									scl_low_o <= 1'b1;
									state_q   <= ENG_IDLE;
									done_o    <= 1'b1;
								end
							endcase
						end
						ENG_STOP: begin
							unique case (phase_q)
								2'h0: sda_low_o <= 1'b1;
								2'h1: scl_low_o <= 1'b0;
								2'h2: sda_low_o <= 1'b0;
								2'h3: begin
									state_q <= ENG_IDLE;
									done_o  <= 1'b1;
								end
							endcase
						end
						default: begin
							unique case (phase_q)
								2'h0: sda_low_o <= ~shift_q[8];
								2'h1: scl_low_o <= 1'b0;
								2'h2: rxsh_q    <= {rxsh_q[7:0], sda_i};
								2'h3: begin
									scl_low_o <= 1'b1;
									shift_q   <= {shift_q[7:0], 1'b1};
									bit_q     <= bit_q + 4'h1;
									if (bit_q == 4'h8) begin
										rdata_o <= rxsh_q[8:1];
										ack_o   <= rxsh_q[0];
										state_q <= ENG_IDLE;
										done_o  <= 1'b1;
									end
								end
							endcase
						end
					endcase
				end
			end
		end
	end

endmodule : vlh_i2c_engine

// ---- sim/vlh_chip_model.sv ----
`timescale 1ns/100ps
module vlh_chip_model (
	input  wire logic       clk_i, tx_rst_n_i, rx_rst_n_i,
	input  wire logic [1:0] evt_i,
	input  wire logic [2:0] oe_i, scl_oe_i,
	output logic            tx_int_n_o, rx_int_n_o,
	output logic [2:0]      sda_o,
	output logic [8:0]      seen_o
);
	logic [2:0] scl_q;
	logic [2:0] scl_rise;
	// Pull-up wins unless the host pulls low; the model never acknowledges
	assign sda_o    = ~oe_i;
	assign scl_rise = scl_q & ~scl_oe_i;
	always_ff @(posedge clk_i) begin
		tx_int_n_o <= !(tx_rst_n_i && evt_i[0]);
		rx_int_n_o <= !(rx_rst_n_i && evt_i[1]);
		scl_q      <= scl_oe_i;
		// Clock line released: take the data line level of that bus
		if (|scl_rise) begin
			seen_o <= {seen_o[7:0], |(scl_rise & ~oe_i)};
		end
	end
endmodule : vlh_chip_model

// ---- sim/vlh_host_ctrl_checker.sv ----
`timescale 1ns/100ps
module vlh_checker (
	input wire logic clk_i, rst_i, s_awvalid_i, s_wvalid_i, s_awready_o, s_bvalid_o, s_arvalid_i,
	input wire logic s_arready_o, s_rvalid_o, irq_o, tx_rst_n_o, active_port_o, video_out_en_o,
	input wire logic display_id_eeprom_write_guard_o, port_one_hotplug_enable_low_o,
	input wire logic port_two_hotplug_enable_low_o,
	input wire logic [2:0] mgmt_scl_o, mgmt_sda_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wr_answer_a: assert property (s_awvalid_i && s_wvalid_i && !s_awready_o && !s_bvalid_o
		|=> s_awready_o && s_bvalid_o) else $error("write not answered");
	rd_answer_a: assert property (s_arvalid_i && !s_arready_o && !s_rvalid_o |=> s_rvalid_o)
		else $error("read not answered");
	od_low_a: assert property (mgmt_scl_o == 3'h0 && mgmt_sda_o == 3'h0) else $error("line driven high");
	hp_pair_a: assert property (port_one_hotplug_enable_low_o == port_two_hotplug_enable_low_o)
		else $error("hot-plug lines differ");
	vid_gate_a: assert property (video_out_en_o |-> tx_rst_n_o) else $error("video while in reset");
	chip_rst_a: assert property ($fell(rst_i) |-> !tx_rst_n_o [*4] ##[1:4] tx_rst_n_o)
		else $error("reset pulse length");
	rst_state_a: assert property (disable iff (1'b0) rst_i |=> !irq_o && !video_out_en_o && !tx_rst_n_o
		&& display_id_eeprom_write_guard_o && !active_port_o) else $error("reset state");
	port_hold_a: assert property ($changed(active_port_o) |=> $stable(active_port_o) [*2])
		else $error("port toggles");
	cover property ($rose(irq_o));
	cover property ($changed(active_port_o));
	cover property ($rose(video_out_en_o));
endmodule : vlh_checker
bind vlh_host_ctrl vlh_checker i_chk (.*);

// ---- sim/vlh_host_ctrl_bench.sv ----
`timescale 1ns/100ps
module vlh_host_ctrl_bench;
	logic clk_i = 0, rst_i = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr_, bv, arr, rv, irq, txr, rxr;
	logic txi, rxi, grd, hp1, hp2, prt, vid;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rd_;
	logic [1:0] evt = 2'h0, br, rr;
	logic [2:0] sda, soe, coe;
	logic [8:0] seen;
	int errors = 0, compares = 0, cyc = 0;
	wire [6:0] pins = {txr, rxr, grd, hp1, hp2, prt, vid};
	always #2.5 clk_i = ~clk_i;
	vlh_host_ctrl #(.PORT_SWITCH_CYCLES(50), .RESET_CYCLES(4), .QUARTER_CYCLES(2)) i_dut (.clk_i, .rst_i,
		.ce_i(1'b1), .s_awaddr_i(awa), .s_awvalid_i(awv), .s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(4'hF),
		.s_wvalid_i(wv), .s_wready_o(wr_), .s_bresp_o(br), .s_bvalid_o(bv), .s_bready_i(bry), .s_araddr_i(ara),
		.s_arvalid_i(arv), .s_arready_o(arr), .s_rdata_o(rd_), .s_rresp_o(rr), .s_rvalid_o(rv), .s_rready_i(rry),
		.irq_o(irq), .tx_rst_n_o(txr), .rx_rst_n_o(rxr), .tx_int_n_i(txi), .rx_int_n_i(rxi), .mgmt_scl_o(),
		.mgmt_scl_oe_o(coe), .mgmt_sda_i(sda), .mgmt_sda_o(), .mgmt_sda_oe_o(soe),
		.display_id_eeprom_write_guard_o(grd), .port_one_hotplug_enable_low_o(hp1),
		.port_two_hotplug_enable_low_o(hp2), .active_port_o(prt), .video_out_en_o(vid));
	vlh_chip_model i_chips (.clk_i, .tx_rst_n_i(txr), .rx_rst_n_i(rxr), .evt_i(evt), .oe_i(soe),
		.tx_int_n_o(txi), .rx_int_n_o(rxi), .sda_o(sda), .scl_oe_i(coe), .seen_o(seen));
	task chk(input logic [31:0] s, e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		do begin
			@(posedge clk_i);
			if (awr === 1'b1) awv <= 0;
			if (wr_ === 1'b1) wv <= 0;
		end while (bv !== 1'b1);
		bry <= 0;
		chk(32'(br), 32'(r));
		repeat (2) @(posedge clk_i);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		ara <= a;
		arv <= 1;
		rry <= 1;
		do begin
			@(posedge clk_i);
			if (arr === 1'b1) arv <= 0;
		end while (rv !== 1'b1);
		rry <= 0;
		chk(rd_, e);
		chk(32'(rr), 32'(r));
		@(posedge clk_i);
	endtask : rd
	task wirq;
		repeat (200) if (irq !== 1'b1) @(posedge clk_i);
		chk(32'(irq), 32'h1);
	endtask : wirq
	task cmd(input logic [31:0] d);
		wr(vlh_pkg::REG_CMD, d, 2'h0);
		wirq();
		rd(vlh_pkg::REG_IRQ_STAT, 32'h4, 2'h0);
	endtask : cmd
	task print_verdict;
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		repeat (20) @(posedge clk_i);
		chk(32'(pins), 32'h7C);
		rd(vlh_pkg::REG_CTRL, 32'h0, 2'h0);
		rd(8'hFC, 32'h0, 2'h2);
		wr(8'hF8, 32'hF, 2'h2);
		$display("reset and map test done");
		wr(vlh_pkg::REG_CTRL, 32'h004, 2'h0);
		chk(32'(pins), 32'h6C);
		wr(vlh_pkg::REG_CTRL, 32'h008, 2'h0);
		chk({29'h0, soe}, 32'h0);
		chk(32'(pins), 32'h70);
		wr(vlh_pkg::REG_CTRL, 32'h1C0, 2'h0);
		chk(32'(pins), 32'h7F);
		wr(vlh_pkg::REG_CTRL, 32'h080, 2'h0);
		chk(32'(pins), 32'h7C);
		rd(vlh_pkg::REG_CTRL, 32'h0, 2'h0);
		$display("pin test done");
		wr(vlh_pkg::REG_IRQ_MASK, 32'h8, 2'h0);
		wr(vlh_pkg::REG_CTRL, 32'h010, 2'h0);
		repeat (30) @(posedge clk_i);
		wr(vlh_pkg::REG_CTRL, 32'h110, 2'h0);
		repeat (20) @(posedge clk_i);
		chk(32'(irq), 32'h0);
		wirq();
		chk(32'(prt), 32'h0);
		wr(vlh_pkg::REG_CTRL, 32'h130, 2'h0);
		rd(vlh_pkg::REG_IRQ_STAT, 32'h8, 2'h0);
		repeat (150) @(posedge clk_i);
		rd(vlh_pkg::REG_IRQ_STAT, 32'h0, 2'h0);
		chk(32'(irq), 32'h0);
		$display("port switch test done");
		for (int i = 0; i < 2; i++) begin
			wr(vlh_pkg::REG_IRQ_MASK, 32'(1 << i), 2'h0);
			evt <= 2'(1 << i);
			repeat (3) @(posedge clk_i);
			evt <= 2'h0;
			wirq();
			rd(vlh_pkg::REG_IRQ_STAT, 32'(1 << i), 2'h0);
		end
		$display("interrupt test done");
		wr(vlh_pkg::REG_CTRL, 32'h101, 2'h0);
		rd(vlh_pkg::REG_STATUS, 32'h15, 2'h0);
		wr(vlh_pkg::REG_IRQ_MASK, 32'h4, 2'h0);
		cmd(32'h000);
		cmd(32'h004);
		chk({23'h0, seen}, 32'h131);
		rd(vlh_pkg::REG_STATUS, 32'h14, 2'h0);
		cmd(32'h001);
		cmd(32'h010);
		cmd(32'h114);
		chk({23'h0, seen}, 32'h123);
		cmd(32'h053);
		rd(vlh_pkg::REG_RDATA, 32'hFF, 2'h0);
		cmd(32'h011);
		cmd(32'h020);
		cmd(32'h5A22);
		chk({23'h0, seen}, 32'h0B5);
		$display("command test done");
		print_verdict();
	end
endmodule : vlh_host_ctrl_bench
